// [verilog/uart_line_defines.vh]
// Constants for the line-format and modem-control block.
// Assumes inclusion by bare name from the design files.
`ifndef UART_LINE_DEFINES_VH
`define UART_LINE_DEFINES_VH

// Register offsets
`define OFS_DATA 3'h0
`define OFS_DIV_HI 3'h1
`define OFS_LFC 3'h3
`define OFS_MLC 3'h4
`define OFS_LST 3'h5
`define OFS_MST 3'h6

// Line format control fields
`define LFC_LEN_LO 0
`define LFC_LEN_HI 1
`define LFC_STOP 2
`define LFC_PEN 3
`define LFC_PK_LO 4
`define LFC_PK_HI 5
`define LFC_BRK 6
`define LFC_DLAB 7

// Modem line control fields
`define MLC_DTR 0
`define MLC_RTS 1
`define MLC_AUX1 2
`define MLC_AUX2 3
`define MLC_LOOP 4
`define MLC_AFE 5
`define MLC_HALF 7
`define MLC_WMASK 8'hBF

// Reset values
`define RESET_LFC 8'h00
`define RESET_MLC 8'h00
`define RESET_DIV 16'h0001

// Character length and parity codes
`define LEN_5 2'h0
`define PAR_ODD 2'h0
`define PAR_EVEN 2'h1
`define PAR_MARK 2'h2
`define PAR_SPACE 2'h3

// Sixteenth-bit tick counts
`define TICKS_ONE 6'h10
`define TICKS_HALF 6'h08
`define TICKS_ONE_HALF 6'h18
`define TICKS_TWO 6'h20
`define RX_MID 4'h7
`define RX_LAST 4'hF

`endif

// [verilog/serial_char_tx.v]
// Character transmitter: start, 5 to 8 data bits, parity, stop time.
// Assumes a one-cycle tick at sixteen times the bit rate.
`timescale 1ns/100ps
`default_nettype none
`include "uart_line_defines.vh"

module serial_char_tx (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  input wire tick16,
  // Character request
  input wire start,
  input wire [7:0] data,
  output wire busy,
  // Format
  input wire [1:0] len_sel,
  input wire stop_sel,
  input wire par_en,
  input wire [1:0] par_kind,
  input wire half_stop,
  // Serial line, idle at mark
  output reg ser
);

  localparam S_IDLE = 3'h0;
  localparam S_START = 3'h1;
  localparam S_DATA = 3'h2;
  localparam S_PAR = 3'h3;
  localparam S_STOP = 3'h4;

  reg [2:0] state;
  reg [5:0] tcnt;
  reg [7:0] shreg;
  reg [2:0] bits_left;
  reg par_bit;
  reg [5:0] stop_ticks;
  wire [7:0] masked;
  wire [5:0] limit;
  reg next_par;
  reg [5:0] next_stop;

  assign masked = data & (8'hFF >> (2'h3 - len_sel));
  assign limit = (state == S_STOP) ? stop_ticks : `TICKS_ONE;
  assign busy = (state != S_IDLE);

  always @* begin
    case (par_kind)
      `PAR_ODD: next_par = ~^masked;
      `PAR_EVEN: next_par = ^masked;
      `PAR_MARK: next_par = 1'b1;
      default: next_par = 1'b0;
    endcase
    if (half_stop) begin
      next_stop = `TICKS_HALF;
    end else if (!stop_sel) begin
      next_stop = `TICKS_ONE;
    end else if (len_sel == `LEN_5) begin
      next_stop = `TICKS_ONE_HALF;
    end else begin
      next_stop = `TICKS_TWO;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      state <= S_IDLE;
      tcnt <= 6'h00;
      shreg <= 8'h00;
      bits_left <= 3'h0;
      par_bit <= 1'b0;
      stop_ticks <= `TICKS_ONE;
      ser <= 1'b1;
    end else if (state == S_IDLE) begin
      // Format is latched here, except par_en, which S_DATA reads live, so a write to it can tear a character
      if (start) begin
        shreg <= masked;
        bits_left <= 3'h4 + {1'b0, len_sel};
        par_bit <= next_par;
        stop_ticks <= next_stop;
        tcnt <= 6'h00;
        ser <= 1'b0;
        state <= S_START;
      end
    end else if (tick16) begin
      if (tcnt != limit - 6'h01) begin
        tcnt <= tcnt + 6'h01;
      end else begin
        tcnt <= 6'h00;
        case (state)
          S_START: begin
            ser <= shreg[0];
            state <= S_DATA;
          end
          S_DATA: begin
            if (bits_left == 3'h0) begin
              ser <= par_en ? par_bit : 1'b1;
              state <= par_en ? S_PAR : S_STOP;
            end else begin
              ser <= shreg[1];
              shreg <= {1'b0, shreg[7:1]};
              bits_left <= bits_left - 3'h1;
            end
          end
          S_PAR: begin
            ser <= 1'b1;
            state <= S_STOP;
          end
          default: begin
            ser <= 1'b1;
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// [verilog/uart_line_modem_control.v]
// Line format, modem control, divisor page, receiver and flow control.
// Assumes pins synchronous to ref_clk and a single-cycle register port.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "uart_line_defines.vh"

// Operation
// - Length field picks 5, 6, 7 or 8 data bits both directions.
// - Stop select clear gives one stop bit, else 1.5 for 5-bit, 2 otherwise.
// - Parity enable clear means no parity sent or checked.
// - Break bit holds serial output at space until cleared, outside loopback.
// - Divisor select bit maps shared offsets to divisor registers.
// - DTR pin is the inverse of its control bit outside loopback.
// - RTS pin is the inverse of its control bit unless auto RTS or loopback.
// - Loopback routes first auxiliary output to ring indicate path.
// - Loopback routes second auxiliary output to carrier detect path.
// - Modem control bit 4 switches internal loopback on and off.
// - Flow enable clear puts transmit data straight back into receiver.
// - Flow enable with RTS bit: auto RTS from buffer and CTS gating.
// - Flow enable without RTS bit: CTS gating only, manual RTS.
// - Flow enable clear: no auto RTS and no CTS gating.
// - Half stop mode sends half a stop bit between characters.
// - Modem status shows ring indicate, fed by aux one in loopback.
module uart_line_modem_control (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Register port
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  // Serial and modem pins, active low modem lines
  output wire txd,
  input wire rxd,
  output wire dtr_n,
  output wire rts_n,
  output wire aux_output_one_n,
  output wire aux_output_two_n,
  input wire cts_n,
  input wire dsr_n,
  input wire ri_n,
  input wire dcd_n
);

  localparam R_IDLE = 3'h0;
  localparam R_START = 3'h1;
  localparam R_DATA = 3'h2;
  localparam R_PAR = 3'h3;
  localparam R_STOP = 3'h4;

  reg [7:0] line_format_control;
  reg [7:0] modem_line_control_reg;
  reg [15:0] divisor;
  reg [15:0] div_cnt;
  reg tick16;
  reg [7:0] tx_hold;
  reg tx_hold_full;
  reg [7:0] rx_buf;
  reg rx_full;
  reg parity_err;
  reg frame_err;
  reg [2:0] rstate;
  reg [3:0] rcnt;
  reg [7:0] rsh;
  reg [2:0] rbits_left;
  reg rpar_err;
  reg [3:0] modem_prev;
  reg [3:0] modem_delta;
  reg [7:0] next_rdata;
  reg exp_par;

  wire [1:0] len_sel;
  wire par_en;
  wire [1:0] par_kind;
  wire brk;
  wire dlab;
  wire loop;
  wire afe;
  wire auto_rts;
  wire rts_active;
  wire cts_in;
  wire dsr_in;
  wire ri_in;
  wire dcd_in;
  wire [3:0] modem_now;
  wire tx_ser;
  wire tx_busy;
  wire tx_line;
  wire rx_src;
  wire cts_ok;
  wire tx_start;
  wire [7:0] rx_aligned;
  wire data_wr;
  wire data_rd;

  // Field views
  assign len_sel = line_format_control[`LFC_LEN_HI:`LFC_LEN_LO];
  assign par_en = line_format_control[`LFC_PEN];
  assign par_kind = line_format_control[`LFC_PK_HI:`LFC_PK_LO];
  assign brk = line_format_control[`LFC_BRK];
  assign dlab = line_format_control[`LFC_DLAB];
  assign loop = modem_line_control_reg[`MLC_LOOP];
  assign afe = modem_line_control_reg[`MLC_AFE];

  // Flow control
  assign auto_rts = afe & modem_line_control_reg[`MLC_RTS];
  // Buffer full drops RTS so the partner pauses before an overrun
  assign rts_active = auto_rts ? ~rx_full : modem_line_control_reg[`MLC_RTS];
  assign cts_ok = ~afe | cts_in;

  // Modem inputs, internal paths in loopback
  assign cts_in = loop ? rts_active : ~cts_n;
  assign dsr_in = loop ? modem_line_control_reg[`MLC_DTR] : ~dsr_n;
  assign ri_in = loop ? modem_line_control_reg[`MLC_AUX1] : ~ri_n;
  assign dcd_in = loop ? modem_line_control_reg[`MLC_AUX2] : ~dcd_n;
  assign modem_now = {dcd_in, ri_in, dsr_in, cts_in};

  // Output pins, held inactive while looped back
  assign dtr_n = loop | ~modem_line_control_reg[`MLC_DTR];
  assign rts_n = loop | ~rts_active;
  assign aux_output_one_n = loop | ~modem_line_control_reg[`MLC_AUX1];
  assign aux_output_two_n = loop | ~modem_line_control_reg[`MLC_AUX2];

  // Serial path
  assign tx_line = brk ? 1'b0 : tx_ser;
  assign txd = loop ? 1'b1 : tx_line;
  // Diagnostic mode listens to its own transmitter, not the pin
  assign rx_src = (loop | ~afe) ? tx_line : rxd;

  // Data page access only when the divisor page is deselected
  assign data_wr = wr & (addr == `OFS_DATA) & ~dlab;
  assign data_rd = rd & (addr == `OFS_DATA) & ~dlab;

  assign tx_start = tx_hold_full & ~tx_busy & cts_ok;

  serial_char_tx u_tx (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick16(tick16),
    .start(tx_start),
    .data(tx_hold),
    .busy(tx_busy),
    .len_sel(len_sel),
    .stop_sel(line_format_control[`LFC_STOP]),
    .par_en(par_en),
    .par_kind(par_kind),
    .half_stop(modem_line_control_reg[`MLC_HALF]),
    .ser(tx_ser)
  );

  // Baud tick at sixteen times the bit rate; a zero divisor acts as one
  always @(posedge ref_clk) begin
    if (rst) begin
      div_cnt <= 16'h0000;
      tick16 <= 1'b0;
    end else if (div_cnt + 16'h0001 >= divisor) begin
      div_cnt <= 16'h0000;
      tick16 <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick16 <= 1'b0;
    end
  end

  // Register writes
  always @(posedge ref_clk) begin
    if (rst) begin
      line_format_control <= `RESET_LFC;
      modem_line_control_reg <= `RESET_MLC;
      divisor <= `RESET_DIV;
    end else if (wr) begin
      case (addr)
        `OFS_DATA: begin
          if (dlab) begin
            divisor[7:0] <= wdata;
          end
        end
        `OFS_DIV_HI: begin
          if (dlab) begin
            divisor[15:8] <= wdata;
          end
        end
        `OFS_LFC: begin
          line_format_control <= wdata;
        end
        `OFS_MLC: begin
          modem_line_control_reg <= wdata & `MLC_WMASK;
        end
        default: begin
        end
      endcase
    end
  end

  // Transmit holding byte; a write while full overwrites it
  always @(posedge ref_clk) begin
    if (rst) begin
      tx_hold <= 8'h00;
      tx_hold_full <= 1'b0;
    end else if (data_wr) begin
      tx_hold <= wdata;
      tx_hold_full <= 1'b1;
    end else if (tx_start) begin
      tx_hold_full <= 1'b0;
    end
  end

  // Received data, aligned down to the character length
  assign rx_aligned = rsh >> (2'h3 - len_sel);

  always @* begin
    case (par_kind)
      `PAR_ODD: exp_par = ~^rx_aligned;
      `PAR_EVEN: exp_par = ^rx_aligned;
      `PAR_MARK: exp_par = 1'b1;
      default: exp_par = 1'b0;
    endcase
  end

  // Receiver, first stop bit checked only
  always @(posedge ref_clk) begin
    if (rst) begin
      rstate <= R_IDLE;
      rcnt <= 4'h0;
      rsh <= 8'h00;
      rbits_left <= 3'h0;
      rpar_err <= 1'b0;
    end else if (tick16) begin
      rcnt <= rcnt + 4'h1;
      case (rstate)
        R_IDLE: begin
          rcnt <= 4'h0;
          if (!rx_src) begin
            rstate <= R_START;
          end
        end
        R_START: begin
          if (rcnt == `RX_MID) begin
            rcnt <= 4'h0;
            // A start bit gone by mid-bit is noise
            rstate <= rx_src ? R_IDLE : R_DATA;
            rbits_left <= 3'h4 + {1'b0, len_sel};
            rpar_err <= 1'b0;
          end
        end
        R_DATA: begin
          if (rcnt == `RX_LAST) begin
            rsh <= {rx_src, rsh[7:1]};
            rbits_left <= rbits_left - 3'h1;
            if (rbits_left == 3'h0) begin
              rstate <= par_en ? R_PAR : R_STOP;
            end
          end
        end
        R_PAR: begin
          if (rcnt == `RX_LAST) begin
            rpar_err <= (rx_src != exp_par);
            rstate <= R_STOP;
          end
        end
        R_STOP: begin
          if (rcnt == `RX_LAST) begin
            rstate <= R_IDLE;
          end
        end
        default: begin
          rstate <= R_IDLE;
        end
      endcase
    end
  end

  // Receive buffer and line flags; a new event wins over a clearing read
  always @(posedge ref_clk) begin
    if (rst) begin
      rx_buf <= 8'h00;
      rx_full <= 1'b0;
      parity_err <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      if (tick16 && rstate == R_STOP && rcnt == `RX_LAST) begin
        rx_buf <= rx_aligned;
        rx_full <= 1'b1;
        parity_err <= rpar_err;
        frame_err <= ~rx_src;
      end else begin
        if (data_rd) begin
          rx_full <= 1'b0;
        end
        if (rd && addr == `OFS_LST) begin
          parity_err <= 1'b0;
          frame_err <= 1'b0;
        end
      end
    end
  end

  // Modem status edges; ring indicate flags only a rise
  always @(posedge ref_clk) begin
    if (rst) begin
      modem_prev <= 4'h0;
      modem_delta <= 4'h0;
    end else begin
      modem_prev <= modem_now;
      if (rd && addr == `OFS_MST) begin
        modem_delta <= (modem_now ^ modem_prev) & {1'b1, ~modem_prev[2], 2'h3};
      end else begin
        modem_delta <= modem_delta | ((modem_now ^ modem_prev) & {1'b1, ~modem_prev[2], 2'h3});
      end
    end
  end

  // Read mux, data valid in the cycle after the strobe
  always @* begin
    next_rdata = 8'h00;
    case (addr)
      `OFS_DATA: next_rdata = dlab ? divisor[7:0] : rx_buf;
      `OFS_DIV_HI: next_rdata = dlab ? divisor[15:8] : 8'h00;
      `OFS_LFC: next_rdata = line_format_control;
      `OFS_MLC: next_rdata = modem_line_control_reg;
      `OFS_LST: next_rdata = {1'b0, ~tx_busy & ~tx_hold_full, ~tx_hold_full, 1'b0,
                              frame_err, parity_err, 1'b0, rx_full};
      `OFS_MST: next_rdata = {modem_now, modem_delta};
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// [verification/uart_line_modem_control_properties.sv]
// Checker for the line format and modem control block.
// Assumes one clock; shadows the two control registers from the writes.
`timescale 1ns/100ps
`default_nettype none
module line_ctrl_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Pins
  input wire logic txd,
  input wire logic dtr_n,
  input wire logic rts_n,
  input wire logic aux_output_one_n,
  input wire logic aux_output_two_n
);
  logic [7:0] lfc;
  logic [7:0] mlc;
  logic [2:0] age;
  // Shadows, as the registers are out of sight
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lfc <= 8'h00;
      mlc <= 8'h00;
      age <= 3'h0;
    end else begin
      if (wr && addr == 3'h3)
        lfc <= wdata;
      if (wr && addr == 3'h4)
        mlc <= wdata & 8'hBF;
      age <= (wr && addr == 3'h4) ? 3'h0 : age + {2'h0, age != 3'h7};
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence read_of(logic [2:0] a);
    rd && addr == a;
  endsequence
  dtr_pin_a: assert property (!mlc[4] |-> dtr_n == ~mlc[0]) else $error("dtr pin");
  rts_pin_a: assert property (!mlc[4] && !(mlc[5] && mlc[1]) |-> rts_n == ~mlc[1])
    else $error("rts pin");
  aux_pin_a: assert property (!mlc[4] |-> {aux_output_two_n, aux_output_one_n} == ~mlc[3:2])
    else $error("aux pins");
  loop_quiet_a: assert property (mlc[4] |-> txd && dtr_n && rts_n && aux_output_one_n && aux_output_two_n)
    else $error("loop pins");
  break_line_a: assert property (lfc[6] && !mlc[4] |-> !txd) else $error("break line");
  format_readback_a: assert property (read_of(3'h3) |=> rdata == lfc) else $error("format read");
  modem_readback_a: assert property (read_of(3'h4) |=> rdata == mlc) else $error("modem read");
  rdata_idle_a: assert property (!rd |=> rdata == 8'h00) else $error("rdata idle");
  page_select_a: assert property (read_of(3'h1) ##0 !lfc[7] |=> rdata == 8'h00) else $error("page");
  loop_status_a: assert property (read_of(3'h6) ##0 (mlc[4] && age == 3'h7) |=>
    rdata[7:4] == {mlc[3], mlc[2], mlc[0], mlc[1]}) else $error("loop status");
endmodule
bind uart_line_modem_control line_ctrl_props i_props (
  .ref_clk(ref_clk),
  .rst(rst),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .rd(rd),
  .rdata(rdata),
  .txd(txd),
  .dtr_n(dtr_n),
  .rts_n(rts_n),
  .aux_output_one_n(aux_output_one_n),
  .aux_output_two_n(aux_output_two_n)
);
`default_nettype wire

// [verification/serial_far_end.sv]
// Remote serial port on the far side of the line.
// Assumes a divisor of one, so a bit lasts 16 clock cycles.
`timescale 1ns/100ps
`default_nettype none
module serial_far_end (
  // Clock
  input wire logic ref_clk,
  // Serial line
  input wire logic txd,
  output logic rxd,
  // Modem lines toward the block
  output logic cts_n,
  output logic dsr_n,
  output logic ri_n,
  output logic dcd_n,
  // Bits after the start bit, stop included
  input wire logic [3:0] nbits
);
  logic [11:0] frames[$];
  int gaps[$];
  time last;
  logic [11:0] sh;
  // Ring and carrier opposite to what loopback shows
  initial begin
    rxd = 1'h1;
    cts_n = 1'h0;
    dsr_n = 1'h1;
    ri_n = 1'h0;
    dcd_n = 1'h1;
    last = 0;
  end
  // Least significant bit first
  initial forever begin
    @(negedge txd);
    gaps.push_back(int'(($time - last) / 50));
    last = $time;
    sh = 12'h000;
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < nbits; i++) begin
      // Stop sampled early so a half stop still fits
      repeat ((i == nbits - 1) ? 10 : 16) @(posedge ref_clk);
      sh[i] = txd;
    end
    frames.push_back(sh);
  end
  // Plain 8-bit character, one stop bit
  task automatic send(input logic [7:0] b);
    rxd <= 1'h0;
    repeat (16) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (16) @(posedge ref_clk);
    end
    rxd <= 1'h1;
    repeat (16) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// [verification/uart_line_modem_control_tb_top.sv]
// Testbench for the line format and modem control block.
// Assumes the far-end model and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module uart_line_modem_control_tb_top;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [3:0] nb = 4'h9;
  wire [7:0] rdata;
  wire txd, rxd, dtr_n, rts_n, aux1_n, aux2_n, cts_n, dsr_n, ri_n, dcd_n;
  int n_fail = 0;
  int n_compared = 0;
  int unsigned seed = 73398;
  logic [7:0] mtab [4] = '{8'hFF, 8'h03, 8'h0C, 8'h58};
  always #25 ref_clk = ~ref_clk;
  uart_line_modem_control i_dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .txd(txd),
    .rxd(rxd),
    .dtr_n(dtr_n),
    .rts_n(rts_n),
    .aux_output_one_n(aux1_n),
    .aux_output_two_n(aux2_n),
    .cts_n(cts_n),
    .dsr_n(dsr_n),
    .ri_n(ri_n),
    .dcd_n(dcd_n)
  );
  serial_far_end i_far (
    .ref_clk(ref_clk),
    .txd(txd),
    .rxd(rxd),
    .cts_n(cts_n),
    .dsr_n(dsr_n),
    .ri_n(ri_n),
    .dcd_n(dcd_n),
    .nbits(nb)
  );
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // Data bits, then parity if on, then stop
  function automatic logic [11:0] frame_of(input logic [7:0] b, input logic [7:0] f);
    logic [7:0] d;
    d = b & 8'((9'h001 << (5 + f[1:0])) - 9'h001);
    return {4'h0, d} | (12'(f[3] ? {1'h1, ~f[4] ^ (^d & ~f[5])} : 2'h1) << (5 + f[1:0]));
  endfunction
  task final_report();
    $display("TB: compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge ref_clk);
    wr <= 1'h0;
  endtask
  task rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge ref_clk);
    rd <= 1'h0;
    @(negedge ref_clk);
    v = rdata;
  endtask
  // Bounded wait on the line, on ready-to-send, or on captured frames
  task wait_on(input int sel, input int v);
    int n;
    for (n = 0; n < 3000; n++) begin
      if (sel == 0 ? txd === v[0] : sel == 1 ? rts_n === v[0] : i_far.frames.size() >= v)
        break;
      @(posedge ref_clk);
    end
    if (n == 3000) begin
      n_fail++;
      $display("ERROR wait %0d expected %0d seen timeout", sel, v);
      final_report();
    end
  endtask
  initial begin
    logic [7:0] v, a, b, f, m;
    int n, e;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    rd_reg(3'h3, v);
    chk("format reset", 8'h00, v);
    foreach (mtab[i]) begin
      m = mtab[i];
      wr_reg(3'h4, m);
      repeat (8) @(posedge ref_clk);
      e = m[4] ? 5'h1F : {1'h1, ~m[0], ~m[1], ~m[2], ~m[3]};
      chk("pins", e, {txd, dtr_n, rts_n, aux1_n, aux2_n});
      rd_reg(3'h4, v);
      chk("modem readback", m & 8'hBF, v);
      rd_reg(3'h6, v);
      if (m[4])
        chk("loop status", {m[3], m[2], m[0], m[1]}, v[7:4]);
      else
        chk("pin status", 4'h5, v[7:4]);
    end
    // Every length, stop and parity code, last four with half stop
    for (int k = 0; k < 16; k++) begin
      f = {2'h0, k[3:2], k % 3 != 0, k[1] ^ k[3], k[1:0]};
      n = 5 + f[1:0];
      nb <= 4'(n + f[3] + 1);
      e = 16 * (1 + n + f[3]) + (k > 11 ? 8 : f[2] ? (n == 5 ? 24 : 32) : 16);
      wr_reg(3'h4, k > 11 ? 8'hA0 : 8'h20);
      wr_reg(3'h3, f);
      a = rnd();
      b = rnd();
      i_far.frames.delete();
      i_far.gaps.delete();
      wr_reg(3'h0, a);
      wait_on(0, 0);
      wr_reg(3'h0, b);
      wait_on(2, 2);
      chk("first char", frame_of(a, f), i_far.frames[0]);
      chk("second char", frame_of(b, f), i_far.frames[1]);
      chk("spacing", e, (i_far.gaps[1] >= e && i_far.gaps[1] <= e + 3) ? e : i_far.gaps[1]);
    end
    wr_reg(3'h4, 8'h00);
    wr_reg(3'h3, 8'h03);
    nb <= 4'h9;
    a = rnd();
    i_far.frames.delete();
    wr_reg(3'h0, a);
    wait_on(2, 1);
    repeat (16) @(posedge ref_clk);
    rd_reg(3'h0, v);
    chk("looped char", a, v);
    // Clear to send withheld: gated with flow on, ignored with it off
    for (int k = 0; k < 3; k++) begin
      i_far.frames.delete();
      wr_reg(3'h4, k == 0 ? 8'h22 : k == 1 ? 8'h20 : 8'h00);
      i_far.cts_n <= 1'h1;
      a = rnd();
      wr_reg(3'h0, a);
      if (k < 2) begin
        // Line must stay at mark for the whole window, not just at its end
        m = 8'h01;
        repeat (40) begin
          @(posedge ref_clk);
          m[0] = m[0] & txd;
        end
        chk("stalled line", 1, m[0]);
        i_far.cts_n <= 1'h0;
      end
      wait_on(0, 0);
      wait_on(2, 1);
    end
    // Diagnostic pass looped its byte back; drain it so auto RTS starts clear
    repeat (16) @(posedge ref_clk);
    rd_reg(3'h0, v);
    chk("diagnostic char", a, v);
    wr_reg(3'h4, 8'h22);
    i_far.cts_n <= 1'h0;
    a = rnd();
    @(negedge ref_clk);
    chk("ready", 0, rts_n);
    @(posedge ref_clk);
    i_far.send(a);
    wait_on(1, 1);
    rd_reg(3'h5, v);
    chk("line status", 8'h61, v);
    rd_reg(3'h0, v);
    chk("received char", a, v);
    @(negedge ref_clk);
    chk("ready again", 0, rts_n);
    wr_reg(3'h3, 8'h43);
    @(negedge ref_clk);
    chk("break", 0, txd);
    wr_reg(3'h3, 8'h03);
    @(negedge ref_clk);
    chk("break end", 1, txd);
    wr_reg(3'h3, 8'h83);
    wr_reg(3'h0, 8'h02);
    wr_reg(3'h1, 8'h5A);
    rd_reg(3'h0, v);
    chk("divisor low", 8'h02, v);
    rd_reg(3'h1, v);
    chk("divisor high", 8'h5A, v);
    wr_reg(3'h0, 8'h01);
    wr_reg(3'h1, 8'h00);
    wr_reg(3'h3, 8'h03);
    rd_reg(3'h1, v);
    chk("data page", 8'h00, v);
    rd_reg(3'h7, v);
    chk("unmapped", 8'h00, v);
    final_report();
  end
endmodule
`default_nettype wire
